// ---- hw/keyswitch_status_logic.sv ----
// Purpose: Keyswitch arming, silencing, tamper lockout, indicator lamps
// Assumes: One partition; panel logic inputs share CLK
// Notes:   Contact pins are synchronised and debounced before use
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module keyswitch_status_logic
  import ks_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = ks_pkg::HOLD_CYC_DEF,
  parameter int unsigned DEB_CYC   = ks_pkg::DEB_CYC_DEF,
  parameter int unsigned FLASH_CYC = ks_pkg::FLASH_CYC_DEF
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 ARST_N,
  // Register port
  input  wire logic [ks_pkg::AW-1:0] ADDR,
  input  wire logic [31:0]          WDATA,
  input  wire logic                 WR_STB,
  input  wire logic                 RD_STB,
  output logic      [31:0]          RDATA,
  output logic                      IRQ,
  // Contact pins
  input  wire logic                 ZONE7_KEY_CLOSED,
  input  wire logic                 ZONE6_TAMPER_OPEN,
  // Panel state
  input  wire logic                 READY,
  input  wire logic                 ALARM_ACTIVE,
  input  wire logic                 FIRE_ALARM,
  input  wire logic                 USER_DISARM,
  input  wire logic                 AC_PRESENT,
  input  wire logic                 TX_EXHAUSTED,
  input  wire logic                 TX_SUCCESS,
  input  wire logic                 MAIN_LINE_FAULT,
  input  wire logic                 BACKUP_LINE_FAULT,
  input  wire logic                 KEYPAD_TONE,
  input  wire logic                 KEY_ACK_BEEP,
  // Partition control
  output logic      [1:0]           ARM_MODE,
  output logic                      NAC_SILENCE,
  output logic                      FIRE_SILENCED_MSG,
  output logic                      ALARM_MEMORY,
  output logic                      ALARM_MEM_CLEAR,
  output logic                      DET_PWR_RESET,
  output logic                      ZONE6_FAULT,
  output logic                      ZONE7_ZONE_FAULT,
  // Open and close reports
  output logic                      REPORT_STB,
  output logic                      REPORT_CLOSE,
  output logic      [7:0]           REPORT_USER,
  // Keyswitch LEDs
  output logic                      LED_GREEN,
  output logic                      LED_RED,
  // Trigger output connector
  output logic                      LAMP_AC,
  output logic                      COMM_FAIL_LAMP,
  output logic                      LAMP_DIALER1,
  output logic                      LAMP_DIALER2,
  output logic                      TRIG5_SOUNDER
);
  import ks_pkg::*;

  typedef enum logic [1:0] {KS_IDLE, KS_HOLD, KS_WAIT_REL} ks_e;

  logic [11:0]    cfg_r;
  logic [NEV-1:0] int_stat_r;
  logic [NEV-1:0] int_mask_r;
  logic [NEV-1:0] ev;
  ks_e            st_r;
  arm_e           arm_r;
  logic [31:0]    hold_cnt_r;
  logic           key_db;
  logic           key_rise;
  logic           tamper_db;
  logic           tamper_lock_r;
  logic           silenced_r;
  logic           fire_sil_r;
  logic           alarm_mem_r;
  logic           comm_r;
  logic           comm_ok_r;
  logic           dial1_r;
  logic           dial2_r;
  logic [31:0]    flash_cnt_r;
  logic           fast_r;
  logic           slow_r;
  logic [1:0]     slow_div_r;
  logic           ks_en;
  logic           oc_en;
  logic           fire_opt;
  logic [3:0]     trig_cfg;
  logic           accept;
  logic           armed;
  logic           do_silence;
  logic           do_clear;
  logic           do_disarm;
  logic           do_hold;
  logic           arm_away;
  logic           arm_stay;
  logic           wr_int;

  assign ks_en    = cfg_r[CFG_KS_EN_BIT];
  assign oc_en    = cfg_r[CFG_OC_EN_BIT];
  assign fire_opt = cfg_r[CFG_OPT_LSB +: 4] == KS_OPT_FIRE;
  assign trig_cfg = cfg_r[CFG_TRIG_LSB +: 4];
  assign armed    = arm_r != ARM_OFF;
  assign wr_int   = WR_STB && ADDR == INT_STAT_OFS;

  // Contact inputs
  ks_debounce #(.DEB_CYC(DEB_CYC)) u_key (
    .CLK     (CLK),
    .ARST_N  (ARST_N),
    .PIN_RAW (ZONE7_KEY_CLOSED),
    .LEVEL   (key_db),
    .ROSE    (key_rise)
  );

  ks_debounce #(.DEB_CYC(DEB_CYC)) u_tamper (
    .CLK     (CLK),
    .ARST_N  (ARST_N),
    .PIN_RAW (ZONE6_TAMPER_OPEN),
    .LEVEL   (tamper_db),
    .ROSE    ()
  );

  // Closure decoding; an open tamper blocks closures at once
  always_comb begin
    accept     = key_rise && ks_en && !tamper_lock_r && !tamper_db;
    do_silence = 1'b0;
    do_clear   = 1'b0;
    do_disarm  = 1'b0;
    do_hold    = 1'b0;
    if (accept) begin
      if (fire_opt) begin
        do_silence = FIRE_ALARM && !silenced_r;
      end else if (silenced_r) begin
        do_clear = 1'b1;
      end else if (ALARM_ACTIVE) begin
        do_silence = 1'b1;
        do_disarm  = armed;
      end else if (armed) begin
        do_disarm = 1'b1;
      end else begin
        do_hold = 1'b1;
      end
    end
  end

  // Hold timing: release decides away, the full hold decides stay
  assign arm_away = st_r == KS_HOLD && !key_db;
  assign arm_stay = st_r == KS_HOLD && key_db &&
                    hold_cnt_r >= 32'(HOLD_CYC - 1);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r       <= KS_IDLE;
      hold_cnt_r <= 32'h0;
    end else begin
      case (st_r)
        KS_IDLE: begin
          hold_cnt_r <= 32'h0;
          if (do_hold) begin
            st_r <= KS_HOLD;
          end else if (key_rise) begin
            st_r <= KS_WAIT_REL;
          end
        end
        KS_HOLD: begin
          hold_cnt_r <= hold_cnt_r + 32'h1;
          if (arm_away) begin
            st_r <= KS_IDLE;
          end else if (arm_stay || tamper_db || USER_DISARM) begin
            st_r <= KS_WAIT_REL;
          end
        end
        KS_WAIT_REL: begin
          hold_cnt_r <= 32'h0;
          if (!key_db) begin
            st_r <= KS_IDLE;
          end
        end
        default: begin
          st_r <= KS_IDLE;
        end
      endcase
    end
  end

  // Arming state; a disarm from any source wins
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      arm_r <= ARM_OFF;
    end else if (do_disarm || USER_DISARM) begin
      arm_r <= ARM_OFF;
    end else if (arm_stay && !tamper_db) begin
      arm_r <= ARM_STAY;
    end else if (arm_away && !tamper_db) begin
      arm_r <= ARM_AWAY;
    end
  end

  // Tamper lockout, released only when restored and disarmed
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tamper_lock_r <= 1'b0;
    end else if (tamper_db) begin
      tamper_lock_r <= 1'b1;
    end else if (arm_r == ARM_OFF) begin
      tamper_lock_r <= 1'b0;
    end
  end

  // Silencing and alarm memory; new alarms win over a clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      silenced_r  <= 1'b0;
      fire_sil_r  <= 1'b0;
      alarm_mem_r <= 1'b0;
    end else begin
      if (do_silence) begin
        silenced_r <= 1'b1;
        fire_sil_r <= FIRE_ALARM;
      end else if (do_clear || (fire_opt && !FIRE_ALARM)) begin
        silenced_r <= 1'b0;
        fire_sil_r <= 1'b0;
      end
      if (ALARM_ACTIVE) begin
        alarm_mem_r <= 1'b1;
      end else if (do_clear) begin
        alarm_mem_r <= 1'b0;
      end
    end
  end

  // Registered partition outputs
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ALARM_MEM_CLEAR  <= 1'b0;
      DET_PWR_RESET    <= 1'b0;
      ZONE6_FAULT      <= 1'b0;
      ZONE7_ZONE_FAULT <= 1'b0;
    end else begin
      ALARM_MEM_CLEAR  <= do_clear;
      DET_PWR_RESET    <= do_clear;
      ZONE6_FAULT      <= tamper_db;
      ZONE7_ZONE_FAULT <= key_db && !ks_en;
    end
  end

  assign ARM_MODE          = arm_r;
  assign NAC_SILENCE       = silenced_r;
  assign FIRE_SILENCED_MSG = fire_sil_r;
  assign ALARM_MEMORY      = alarm_mem_r;

  // Open and close reports for keyswitch actions
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REPORT_STB   <= 1'b0;
      REPORT_CLOSE <= 1'b0;
      REPORT_USER  <= KS_USER_NUM;
    end else begin
      REPORT_STB   <= oc_en && !USER_DISARM && !tamper_db &&
                      (arm_away || arm_stay || do_disarm);
      REPORT_CLOSE <= !do_disarm;
      REPORT_USER  <= KS_USER_NUM;
    end
  end

  // Flash timing; slow is a quarter of fast so the two stay distinct
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flash_cnt_r <= 32'h0;
      fast_r      <= 1'b0;
      slow_r      <= 1'b0;
      slow_div_r  <= 2'h0;
    end else if (flash_cnt_r >= 32'(FLASH_CYC - 1)) begin
      flash_cnt_r <= 32'h0;
      fast_r      <= !fast_r;
      slow_div_r  <= slow_div_r + 2'h1;
      if (slow_div_r == SLOW_DIV_MAX) begin
        slow_r <= !slow_r;
      end
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LED_GREEN <= 1'b0;
      LED_RED   <= 1'b0;
    end else begin
      LED_GREEN <= !armed && READY && !alarm_mem_r;
      if (alarm_mem_r) begin
        LED_RED <= fast_r;
      end else if (arm_r == ARM_AWAY) begin
        LED_RED <= 1'b1;
      end else if (arm_r == ARM_STAY) begin
        LED_RED <= slow_r;
      end else begin
        LED_RED <= 1'b0;
      end
    end
  end

  // Communicator fault lamps; a new fault wins over a disarm
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      comm_r    <= 1'b0;
      comm_ok_r <= 1'b0;
      dial1_r   <= 1'b0;
      dial2_r   <= 1'b0;
    end else begin
      if (TX_EXHAUSTED) begin
        comm_r    <= 1'b1;
        comm_ok_r <= 1'b0;
      end else if (USER_DISARM && comm_ok_r) begin
        comm_r    <= 1'b0;
        comm_ok_r <= 1'b0;
      end else if (TX_SUCCESS && comm_r) begin
        comm_ok_r <= 1'b1;
      end
      if (MAIN_LINE_FAULT) begin
        dial1_r <= 1'b1;
      end else if (USER_DISARM) begin
        dial1_r <= 1'b0;
      end
      if (BACKUP_LINE_FAULT) begin
        dial2_r <= 1'b1;
      end else if (USER_DISARM) begin
        dial2_r <= 1'b0;
      end
    end
  end

  // Trigger connector is shared between indicator lamps and sounder
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LAMP_AC        <= 1'b0;
      COMM_FAIL_LAMP <= 1'b0;
      LAMP_DIALER1   <= 1'b0;
      LAMP_DIALER2   <= 1'b0;
      TRIG5_SOUNDER  <= 1'b0;
    end else begin
      LAMP_AC        <= trig_cfg == TRIG_IND && AC_PRESENT;
      COMM_FAIL_LAMP <= trig_cfg == TRIG_IND && comm_r;
      LAMP_DIALER1   <= trig_cfg == TRIG_IND && dial1_r;
      LAMP_DIALER2   <= trig_cfg == TRIG_IND && dial2_r;
      TRIG5_SOUNDER  <= trig_cfg == TRIG_SOUNDER &&
                        KEYPAD_TONE && !KEY_ACK_BEEP;
    end
  end

  // Register writes and interrupt status
  assign ev[EV_ARM]     = (arm_away || arm_stay) && !USER_DISARM && !tamper_db;
  assign ev[EV_DISARM]  = do_disarm;
  assign ev[EV_SILENCE] = do_silence;
  assign ev[EV_TAMPER]  = tamper_db && !tamper_lock_r;
  assign ev[EV_COMM]    = TX_EXHAUSTED && !comm_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cfg_r      <= CFG_RST;
      int_mask_r <= MASK_RST;
    end else if (WR_STB) begin
      if (ADDR == CFG_OFS) begin
        cfg_r <= WDATA[11:0];
      end
      if (ADDR == INT_MASK_OFS) begin
        int_mask_r <= WDATA[NEV-1:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      int_stat_r <= '0;
    end else begin
      int_stat_r <= (int_stat_r & ~(wr_int ? WDATA[NEV-1:0] : '0)) | ev;
    end
  end

  assign IRQ = |(int_stat_r & int_mask_r);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 32'h0;
    end else if (RD_STB) begin
      case (ADDR)
        CFG_OFS:      RDATA <= {20'h0, cfg_r};
        STAT_OFS:     RDATA <= {22'h0, dial2_r, dial1_r, comm_r,
                                tamper_lock_r, fire_sil_r, silenced_r,
                                alarm_mem_r, key_db, arm_r};
        INT_STAT_OFS: RDATA <= {27'h0, int_stat_r};
        INT_MASK_OFS: RDATA <= {27'h0, int_mask_r};
        default:      RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

  // Checks
  away_arm_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (arm_away && !USER_DISARM && !tamper_db) |=> arm_r == ARM_AWAY)
    else $error("away arm missed");
  stay_arm_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (arm_stay && !USER_DISARM && !tamper_db) |=> arm_r == ARM_STAY &&
    st_r == KS_WAIT_REL)
    else $error("stay arm missed");
  key_disarm_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (accept && armed && !fire_opt && !silenced_r) |=> arm_r == ARM_OFF)
    else $error("keyswitch disarm missed");
  alarm_sil_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (accept && ALARM_ACTIVE && !fire_opt && !silenced_r) |=>
    silenced_r && arm_r == ARM_OFF)
    else $error("alarm silence missed");
  mem_clear_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (accept && silenced_r && !fire_opt && !ALARM_ACTIVE) |=>
    !alarm_mem_r && !silenced_r && DET_PWR_RESET && ALARM_MEM_CLEAR)
    else $error("memory clear missed");
  fire_opt_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (accept && fire_opt && !USER_DISARM) |=> $stable(arm_r) &&
    st_r != KS_HOLD)
    else $error("fire option changed arming");
  led_green_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    LED_GREEN |-> $past(arm_r) == ARM_OFF && $past(READY))
    else $error("green led wrong");
  user_zero_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    REPORT_STB |-> REPORT_USER == 8'h00 && $past(oc_en))
    else $error("report user not zero");
  tamper_lock_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (tamper_lock_r && key_rise && !USER_DISARM) |=> $stable(arm_r) &&
    !silenced_r == !$past(silenced_r))
    else $error("keyswitch acted while locked");
  comm_lamp_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (TX_EXHAUSTED && trig_cfg == TRIG_IND) |=> ##1 COMM_FAIL_LAMP)
    else $error("comm fail lamp not lit");
  sounder_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    TRIG5_SOUNDER |-> $past(trig_cfg) == TRIG_SOUNDER &&
    !$past(KEY_ACK_BEEP))
    else $error("sounder driven wrongly");
endmodule

// ---- hw/ks_debounce.sv ----
// Purpose: Two-flop synchroniser and stability filter for a contact input
// Assumes: Contact may bounce for less than DEB_CYC cycles
// Notes:   Output changes only after the input held steady DEB_CYC cycles
`timescale 1ns/1ps
module ks_debounce #(
  parameter int unsigned DEB_CYC = 4000000
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic ARST_N,
  // Contact
  input  wire logic PIN_RAW,
  output logic      LEVEL,
  output logic      ROSE
);
  logic        meta_r;
  logic        sync_r;
  logic [31:0] cnt_r;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= PIN_RAW;
      sync_r <= meta_r;
    end
  end

  // Restart the count whenever the input agrees with the output, so bounce never passes
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_r <= 32'h0;
      LEVEL <= 1'b0;
      ROSE  <= 1'b0;
    end else begin
      ROSE <= 1'b0;
      if (sync_r == LEVEL) begin
        cnt_r <= 32'h0;
      end else if (cnt_r >= 32'(DEB_CYC - 1)) begin
        cnt_r <= 32'h0;
        LEVEL <= sync_r;
        ROSE  <= sync_r;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
endmodule

// ---- hw/ks_pkg.sv ----
// Purpose: Shared constants for the keyswitch and status logic
// Assumes: 200 MHz system clock
// Notes:   Times are given in their own unit; cycle counts derive from them
package ks_pkg;
  // Clock
  localparam int unsigned CLK_KHZ       = 200000;
  // Times
  localparam int unsigned HOLD_MS       = 10000;
  localparam int unsigned DEBOUNCE_MS   = 20;
  localparam int unsigned FLASH_FAST_MS = 125;
  localparam int unsigned HOLD_CYC_DEF  = HOLD_MS * CLK_KHZ;
  localparam int unsigned DEB_CYC_DEF   = DEBOUNCE_MS * CLK_KHZ;
  localparam int unsigned FLASH_CYC_DEF = FLASH_FAST_MS * CLK_KHZ;
  localparam logic [1:0]  SLOW_DIV_MAX  = 2'h3;
  // Register map
  localparam int          AW            = 8;
  localparam logic [7:0]  CFG_OFS       = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam logic [7:0]  INT_STAT_OFS  = 8'h08;
  localparam logic [7:0]  INT_MASK_OFS  = 8'h0C;
  // Configuration fields
  localparam int          CFG_KS_EN_BIT = 0;
  localparam int          CFG_OC_EN_BIT = 1;
  localparam int          CFG_OPT_LSB   = 4;
  localparam int          CFG_TRIG_LSB  = 8;
  localparam logic [11:0] CFG_RST       = 12'h000;
  localparam logic [3:0]  KS_OPT_FIRE   = 4'h9;
  localparam logic [3:0]  TRIG_SOUNDER  = 4'h0;
  localparam logic [3:0]  TRIG_IND      = 4'h2;
  // Interrupt events
  localparam int          NEV           = 5;
  localparam int          EV_ARM        = 0;
  localparam int          EV_DISARM     = 1;
  localparam int          EV_SILENCE    = 2;
  localparam int          EV_TAMPER     = 3;
  localparam int          EV_COMM       = 4;
  localparam logic [4:0]  MASK_RST      = 5'h00;
  // Reporting
  localparam logic [7:0]  KS_USER_NUM   = 8'h00;
  // Arming state
  typedef enum logic [1:0] {ARM_OFF, ARM_AWAY, ARM_STAY} arm_e;
endpackage

// ---- testbench/ks_contacts.sv ----
// Purpose: Contact model for the keyswitch and tamper switch
// Assumes: Bench requests contact states right after a clock edge
// Notes:   Key contact chatters briefly on every change
`timescale 1ns/1ps
module ks_contacts (
  // Clock
  input  wire logic CLK,
  // Requested states
  input  wire logic KEY_WANT,
  input  wire logic TAMPER_WANT,
  // Contact pins
  output logic      KEY_PIN,
  output logic      TAMPER_PIN
);
  logic       last_r   = 1'b0;
  logic [1:0] bounce_r = 2'h0;
  // Chatter of three cycles stays shorter than the filter
  always_ff @(posedge CLK) begin
    if (KEY_WANT != last_r) begin
      last_r   <= KEY_WANT;
      bounce_r <= 2'h3;
    end else if (bounce_r != 2'h0) begin
      bounce_r <= bounce_r - 2'h1;
    end
  end
  assign KEY_PIN    = (bounce_r != 2'h0) ? bounce_r[0] : last_r;
  // Tamper is a clean snap contact
  assign TAMPER_PIN = TAMPER_WANT;
endmodule

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the keyswitch and status logic
// Assumes: Short counts: hold 200, debounce 4, flash 8 cycles
// Notes:   Reads and reports are checked from queues by a monitor
`timescale 1ns/1ps
module testbench;
  import ks_pkg::*;
  logic clk = 0, arst_n = 0, wr_stb = 0, rd_stb = 0, rd_p = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rs = 32'h62FA;
  logic key = 0, tamp = 0, kc, to, ready = 1, alm = 0, fire = 0;
  logic udis = 0, ac = 0, txe = 0, txs = 0, mlf = 0, blf = 0;
  logic tone = 0, ack = 0, irq, nac, fsm, mem, rstb, rcl, lg, lr;
  logic lac, lcf, ld1, ld2, snd, z6, z7, amc, dpr, lr_d = 0;
  logic [1:0] arm;
  logic [7:0] ru;
  logic [31:0] rq[$];
  logic [8:0] pq[$];
  logic [1:0] cq[$];
  int bad_count = 0, checked = 0;
  int tog = 0, t0 = 0;
  always #2.5 clk = ~clk;
  ks_contacts ks_contacts_i (.CLK(clk), .KEY_WANT(key),
    .TAMPER_WANT(tamp), .KEY_PIN(kc), .TAMPER_PIN(to));
  keyswitch_status_logic #(.HOLD_CYC(200), .DEB_CYC(4), .FLASH_CYC(8))
  keyswitch_status_logic_i (.CLK(clk), .ARST_N(arst_n), .ADDR(addr),
    .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
    .IRQ(irq), .ZONE7_KEY_CLOSED(kc), .ZONE6_TAMPER_OPEN(to),
    .READY(ready), .ALARM_ACTIVE(alm), .FIRE_ALARM(fire),
    .USER_DISARM(udis), .AC_PRESENT(ac), .TX_EXHAUSTED(txe),
    .TX_SUCCESS(txs), .MAIN_LINE_FAULT(mlf), .BACKUP_LINE_FAULT(blf),
    .KEYPAD_TONE(tone), .KEY_ACK_BEEP(ack), .ARM_MODE(arm),
    .NAC_SILENCE(nac), .FIRE_SILENCED_MSG(fsm), .ALARM_MEMORY(mem),
    .ALARM_MEM_CLEAR(amc), .DET_PWR_RESET(dpr), .ZONE6_FAULT(z6),
    .ZONE7_ZONE_FAULT(z7), .REPORT_STB(rstb), .REPORT_CLOSE(rcl),
    .REPORT_USER(ru), .LED_GREEN(lg), .LED_RED(lr), .LAMP_AC(lac),
    .COMM_FAIL_LAMP(lcf), .LAMP_DIALER1(ld1), .LAMP_DIALER2(ld2),
    .TRIG5_SOUNDER(snd));
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (e !== g) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_rd(logic [31:0] e, logic [31:0] g);
    note("rdata", e, g);
  endtask
  task automatic cmp_rep(logic [8:0] e, logic [8:0] g);
    note("report", {23'h0, e}, {23'h0, g});
  endtask
  task automatic cmp_lvl(string n, logic [1:0] e, logic [1:0] g);
    note(n, {30'h0, e}, {30'h0, g});
  endtask
  task automatic cmp_cnt(string n, int e, int g);
    note(n, 32'(e), 32'(g));
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    tick(1);
    wr_stb <= 1'b0;
    tick(1);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    rq.push_back(e);
    addr <= a;
    rd_stb <= 1'b1;
    tick(1);
    rd_stb <= 1'b0;
    tick(1);
  endtask
  // Hold time in cycles, then a settle long enough for the filter
  task automatic press(int n);
    key <= 1'b1;
    tick(n);
    key <= 1'b0;
    tick(30);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Empty queue yields unknown, so a stray result never matches
  always @(posedge clk) begin
    if (rd_p) cmp_rd(rq.size() ? rq.pop_front() : 32'hX, rdata);
    if (rstb === 1'b1)
      cmp_rep(pq.size() ? pq.pop_front() : 9'hX, {rcl, ru});
    if ((amc | dpr) === 1'b1)
      cmp_lvl("clear", cq.size() ? cq.pop_front() : 2'hX, {amc, dpr});
    // Red toggle count tells steady, slow and rapid apart
    if (lr !== lr_d) tog <= tog + 1;
    lr_d <= lr;
    rd_p <= rd_stb;
  end
  initial begin
    tick(20000);
    bad_count++;
    close_out;
  end
  initial begin
    tick(10);
    arst_n <= 1'b1;
    tick(1);
    rd(CFG_OFS, 32'h0);
    rd(INT_MASK_OFS, 32'h0);
    rd(8'h10, 32'h0);
    key <= 1'b1;
    tick(15);
    cmp_lvl("zone7", 2'h1, {1'b0, z7});
    key <= 1'b0;
    tick(30);
    cmp_lvl("arm", 2'h0, arm);
    wr(CFG_OFS, 32'h3);
    pq.push_back(9'h100);
    press(20);
    cmp_lvl("arm", 2'h1, arm);
    cmp_lvl("red", 2'h1, {1'b0, lr});
    rd(STAT_OFS, 32'h1);
    pq.push_back(9'h000);
    press(20);
    cmp_lvl("arm", 2'h0, arm);
    cmp_lvl("green", 2'h1, {1'b0, lg});
    ready <= 1'b0;
    tick(3);
    cmp_lvl("leds", 2'h0, {lg, lr});
    ready <= 1'b1;
    rd(INT_STAT_OFS, 32'h3);
    wr(INT_MASK_OFS, 32'h3);
    tick(2);
    cmp_lvl("irq", 2'h1, {1'b0, irq});
    wr(INT_STAT_OFS, 32'h3);
    tick(2);
    cmp_lvl("irq", 2'h0, {1'b0, irq});
    pq.push_back(9'h100);
    press(260);
    cmp_lvl("arm", 2'h2, arm);
    t0 = tog;
    tick(64);
    cmp_cnt("red_slow", 2, tog - t0);
    pq.push_back(9'h000);
    press(20);
    cmp_lvl("arm", 2'h0, arm);
    alm <= 1'b1;
    press(20);
    cmp_lvl("silence", 2'h1, {1'b0, nac});
    cmp_lvl("memory", 2'h1, {1'b0, mem});
    t0 = tog;
    tick(64);
    cmp_cnt("red_fast", 8, tog - t0);
    cq.push_back(2'h3);
    alm <= 1'b0;
    press(20);
    cmp_lvl("silence", 2'h0, {1'b0, nac});
    cmp_lvl("memory", 2'h0, {1'b0, mem});
    wr(CFG_OFS, 32'h93);
    fire <= 1'b1;
    press(20);
    cmp_lvl("silence", 2'h1, {1'b0, nac});
    cmp_lvl("firemsg", 2'h1, {1'b0, fsm});
    fire <= 1'b0;
    press(20);
    cmp_lvl("arm", 2'h0, arm);
    wr(CFG_OFS, 32'h3);
    tamp <= 1'b1;
    press(20);
    cmp_lvl("zone6", 2'h1, {1'b0, z6});
    cmp_lvl("arm", 2'h0, arm);
    tamp <= 1'b0;
    tick(20);
    // Lock taken while armed must outlast the tamper restore
    pq.push_back(9'h100);
    press(20);
    tamp <= 1'b1;
    tick(20);
    tamp <= 1'b0;
    press(20);
    cmp_lvl("locked", 2'h1, arm);
    udis <= 1'b1;
    tick(1);
    udis <= 1'b0;
    tick(3);
    pq.push_back(9'h100);
    press(20);
    cmp_lvl("unlocked", 2'h1, arm);
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      tone <= rs[0];
      ack <= rs[1];
      tick(3);
      cmp_lvl("sounder", {1'b0, rs[0] & ~rs[1]}, {1'b0, snd});
    end
    wr(CFG_OFS, 32'h203);
    tone <= 1'b1;
    ack <= 1'b0;
    ac <= 1'b1;
    txe <= 1'b1;
    mlf <= 1'b1;
    blf <= 1'b1;
    tick(1);
    txe <= 1'b0;
    mlf <= 1'b0;
    blf <= 1'b0;
    tick(3);
    cmp_lvl("sounder", 2'h0, {1'b0, snd});
    cmp_lvl("lamp_ac", 2'h1, {1'b0, lac});
    cmp_lvl("dialers", 2'h3, {ld1, ld2});
    udis <= 1'b1;
    ac <= 1'b0;
    tick(1);
    udis <= 1'b0;
    tick(3);
    cmp_lvl("lamp_ac", 2'h0, {1'b0, lac});
    cmp_lvl("commfail", 2'h1, {1'b0, lcf});
    cmp_lvl("dialers", 2'h0, {ld1, ld2});
    txs <= 1'b1;
    tick(1);
    txs <= 1'b0;
    udis <= 1'b1;
    tick(1);
    udis <= 1'b0;
    tick(3);
    cmp_lvl("commfail", 2'h0, {1'b0, lcf});
    tick(5);
    cmp_cnt("pending", 0, rq.size() + pq.size() + cq.size());
    close_out;
  end
endmodule
